// ===== hdl/sdac_pair_buf.sv
// Two-entry buffer for stereo sample pairs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sdac_pair_buf
  import sdac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  sdac_stream_if.snk up,
  sdac_stream_if.src dn
);

  sdac_pair_t store [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] fill;
  logic push;
  logic pop;

  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;
  assign up.ready = (fill != 2'h2);
  assign dn.valid = (fill != 2'h0);
  assign dn.data = store[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr] <= up.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        fill <= fill + 2'h1;
      end else if (pop && !push) begin
        fill <= fill - 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hdl/sdac_params.svh
// Constants for the stereo DAC control and output path.
// Assumes inclusion by bare name; definitions only.
`ifndef SDAC_PARAMS_SVH
`define SDAC_PARAMS_SVH

`define SDAC_WORD_BITS 16
`define SDAC_SEL_HI 15
`define SDAC_SEL_LO 14
`define SDAC_SEL_CONFIG 1'b1
`define SDAC_LVL_RESET 16'h0400
`define SDAC_CFG_RESET 16'h0000
`define SDAC_LVL_DEEMPH 13
`define SDAC_LVL_MUTE 12
`define SDAC_ATT_MSB 10
`define SDAC_ATT_UNITY 11'h400
`define SDAC_ATT_SHIFT 10
`define SDAC_CFG_WIDE 12
`define SDAC_CFG_ZDLONG 5
`define SDAC_CFG_RATE_HI 3
`define SDAC_CFG_RATE_LO 2
`define SDAC_CFG_SYNC 1
`define SDAC_FRAME_MAX 9'h1ff
`define SDAC_SLOT_MAX 4'hf
`define SDAC_OS_SHIFT 5
`define SDAC_PWM_MID 5'h07
`define SDAC_PWM_TOP 5'h0e
`define SDAC_Q_SHIFT 14
`define SDAC_ZD_SHORT 2500
`define SDAC_ZD_LONG 12500

`endif

// ===== hdl/sdac_pkg.sv
// Types shared by the stereo DAC modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sdac_pkg;

  typedef logic signed [17:0] sdac_sample_t;

  typedef struct packed {
    sdac_sample_t left;
    sdac_sample_t right;
  } sdac_pair_t;

  typedef enum logic [1:0] {
    SDAC_RATE_44K1 = 2'h0,
    SDAC_RATE_48K0 = 2'h1,
    SDAC_RATE_37K8 = 2'h2,
    SDAC_RATE_32K0 = 2'h3
  } sdac_rate_t;

  typedef enum logic [2:0] {
    SDAC_LD_IDLE = 3'h1,
    SDAC_LD_GRAB = 3'h2,
    SDAC_LD_APPLY = 3'h4
  } sdac_ld_state_t;

endpackage

// ===== hdl/sdac_stream_if.sv
// Valid/ready carrier for stereo sample pairs between DAC modules.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface sdac_stream_if;
  import sdac_pkg::*;
  logic valid;
  logic ready;
  sdac_pair_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== hdl/sdac_top.sv
// Stereo oversampled DAC: serial control registers and PWM output path.
// Assumes sys_clk is the 512 Fs master clock and shift_clock comes from the host.
`include "sdac_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sdac_top
  import sdac_pkg::*;
#(
  parameter int unsigned ZD_SHORT = `SDAC_ZD_SHORT,
  parameter int unsigned ZD_LONG = `SDAC_ZD_LONG
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic shift_clock,
  input wire logic control_serial_in,
  input wire logic control_latch,
  input wire logic audio_bit_clock,
  input wire logic word_select_clock,
  input wire logic audio_data_in,
  output logic left_pwm_a,
  output logic left_pwm_b,
  output logic right_pwm_a,
  output logic right_pwm_b,
  output logic left_zero_flag_n,
  output logic right_zero_flag_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic signed [23:0] sat24(input logic signed [25:0] v);
    if (v > 26'sd8388607) begin
      sat24 = 24'sh7fffff;
    end else if (v < -26'sd8388608) begin
      sat24 = -24'sh800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  function automatic logic signed [4:0] quantise(input logic signed [23:0] v);
    logic signed [23:0] step;
    step = v >>> `SDAC_Q_SHIFT;
    if (step > 24'sd7) begin
      quantise = 5'sd7;
    end else if (step < -24'sd7) begin
      quantise = -5'sd7;
    end else begin
      quantise = step[4:0];
    end
  endfunction

  // Shelf corner per rate; a shift keeps the filter multiplier-free
  function automatic logic [2:0] deemph_shift(input sdac_rate_t rate);
    case (rate)
      SDAC_RATE_44K1: deemph_shift = 3'h3;
      SDAC_RATE_48K0: deemph_shift = 3'h4;
      SDAC_RATE_37K8: deemph_shift = 3'h3;
      SDAC_RATE_32K0: deemph_shift = 3'h2;
      default: deemph_shift = 3'h3;
    endcase
  endfunction

  function automatic sdac_sample_t align_sample(input logic [17:0] sr, input logic wide);
    align_sample = wide ? sr : {sr[15:0], 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: serial control shift register

  logic [15:0] link_shift;

  always_ff @(posedge shift_clock) begin
    link_shift <= {control_serial_in, link_shift[15:1]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control word load and registers

  logic latch_meta;
  logic latch_sync;
  logic latch_prev;
  logic latch_fall;
  sdac_ld_state_t ld_state;
  logic [15:0] cmd_word;
  logic [15:0] level_reg;
  logic [15:0] config_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_meta <= 1'b1;
      latch_sync <= 1'b1;
      latch_prev <= 1'b1;
    end else begin
      latch_meta <= control_latch;
      latch_sync <= latch_meta;
      latch_prev <= latch_sync;
    end
  end

  assign latch_fall = latch_prev && !latch_sync;

  // The shift register is quiet once the latch falls, so the falling
  // strobe serves as the request that makes the word safe to sample here.
  // Load on latch fall
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ld_state <= SDAC_LD_IDLE;
    end else begin
      case (ld_state)
        SDAC_LD_IDLE: begin
          if (latch_fall) begin
            ld_state <= SDAC_LD_GRAB;
          end
        end
        SDAC_LD_GRAB: ld_state <= SDAC_LD_APPLY;
        SDAC_LD_APPLY: ld_state <= SDAC_LD_IDLE;
        default: ld_state <= SDAC_LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_word <= 16'h0000;
    end else if (ld_state == SDAC_LD_GRAB) begin
      cmd_word <= link_shift;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_reg <= `SDAC_LVL_RESET;
      config_reg <= `SDAC_CFG_RESET;
    end else if (ld_state == SDAC_LD_APPLY && !cmd_word[`SDAC_SEL_HI]) begin
      if (cmd_word[`SDAC_SEL_LO] == `SDAC_SEL_CONFIG) begin
        config_reg <= {2'b00, cmd_word[13:0]};
      end else begin
        level_reg <= {2'b00, cmd_word[13:0]};
      end
    end
  end

  logic [10:0] att_code;
  logic deemph_on;
  logic mute_on;
  logic wide_audio;
  logic zd_long;
  logic sync_on;
  sdac_rate_t deemph_rate;

  assign att_code = (level_reg[`SDAC_ATT_MSB:0] > `SDAC_ATT_UNITY) ?
                    `SDAC_ATT_UNITY : level_reg[`SDAC_ATT_MSB:0];
  assign deemph_on = level_reg[`SDAC_LVL_DEEMPH];
  assign mute_on = level_reg[`SDAC_LVL_MUTE];
  assign wide_audio = config_reg[`SDAC_CFG_WIDE];
  assign zd_long = config_reg[`SDAC_CFG_ZDLONG];
  assign sync_on = config_reg[`SDAC_CFG_SYNC];
  assign deemph_rate = sdac_rate_t'(config_reg[`SDAC_CFG_RATE_HI:`SDAC_CFG_RATE_LO]);

  ////////////////////////////////////////////////////////////////////////////
  // Audio input capture

  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [1:0] pin_prev;
  logic bck_rise;
  logic ws_rise;
  logic ws_fall;
  logic [17:0] aud_shift;
  sdac_sample_t left_hold;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_prev <= 2'h0;
    end else begin
      pin_meta <= {audio_data_in, word_select_clock, audio_bit_clock};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync[1:0];
    end
  end

  assign bck_rise = pin_sync[0] && !pin_prev[0];
  assign ws_rise = pin_sync[1] && !pin_prev[1];
  assign ws_fall = !pin_sync[1] && pin_prev[1];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aud_shift <= 18'h00000;
    end else if (bck_rise) begin
      aud_shift <= {aud_shift[16:0], pin_sync[2]};
    end
  end

  sdac_stream_if in_if ();
  sdac_stream_if out_if ();

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      left_hold <= '0;
    end else if (ws_rise) begin
      left_hold <= align_sample(aud_shift, wide_audio);
    end
  end

  // A pair waits here until the buffer accepts it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_if.valid <= 1'b0;
      in_if.data <= '0;
    end else if (ws_fall) begin
      in_if.valid <= 1'b1;
      in_if.data <= '{left: left_hold, right: align_sample(aud_shift, wide_audio)};
    end else if (in_if.ready) begin
      in_if.valid <= 1'b0;
    end
  end

  sdac_pair_buf u_pair_buf (
    .sys_clk (sys_clk),
    .rst (rst),
    .up (in_if),
    .dn (out_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame timing: 512 clocks per sample, 16 clocks per PWM value

  logic [8:0] frame_cnt;
  logic sample_tick;
  logic os_tick;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_cnt <= 9'h000;
    end else if (sync_on && ws_rise) begin
      // Only the slot number restarts; the phase inside a slot runs on,
      // so a resync never cuts or stretches a PWM pulse
      frame_cnt <= {5'h00, frame_cnt[3:0]} + 9'h001;
    end else begin
      frame_cnt <= frame_cnt + 9'h001;
    end
  end

  assign sample_tick = (frame_cnt == `SDAC_FRAME_MAX);
  assign os_tick = (frame_cnt[3:0] == `SDAC_SLOT_MAX);
  assign out_if.ready = sample_tick;

  logic [13:0] zd_period;
  assign zd_period = zd_long ? ZD_LONG[13:0] : ZD_SHORT[13:0];

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel path

  logic pwm_a [2];
  logic pwm_b [2];
  logic zero_n [2];

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    sdac_sample_t new_s;
    sdac_sample_t cur_s;
    logic signed [23:0] interp_acc;
    logic signed [23:0] interp_step;
    logic signed [17:0] interp_s;
    logic signed [29:0] att_prod;
    logic signed [17:0] att_s;
    logic signed [17:0] lp_s;
    logic signed [18:0] lp_diff;
    logic signed [17:0] shaped_s;
    logic signed [23:0] integ1;
    logic signed [23:0] integ2;
    logic signed [23:0] integ3;
    logic signed [23:0] fb;
    logic signed [4:0] q;
    logic [4:0] level;
    logic [13:0] zero_cnt;
    logic [13:0] next_zero_cnt;
    logic taken;

    assign taken = sample_tick && out_if.valid;
    assign new_s = (ch == 0) ? out_if.data.left : out_if.data.right;

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        cur_s <= '0;
        interp_acc <= '0;
        interp_step <= '0;
      end else if (taken) begin
        cur_s <= new_s;
        interp_acc <= {{1{cur_s[17]}}, cur_s, `SDAC_OS_SHIFT'(0)};
        interp_step <= 24'(new_s) - 24'(cur_s);
      end else if (sample_tick) begin
        interp_acc <= {{1{cur_s[17]}}, cur_s, `SDAC_OS_SHIFT'(0)};
        interp_step <= '0;
      end else if (os_tick) begin
        interp_acc <= interp_acc + interp_step;
      end
    end

    assign interp_s = interp_acc[22:`SDAC_OS_SHIFT];

    assign att_prod = interp_s * $signed({1'b0, att_code});

    assign lp_diff = 19'(att_s) - 19'(lp_s);
    assign shaped_s = deemph_on ? 18'((19'(att_s) + 19'(lp_s)) >>> 1) : att_s;

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        att_s <= '0;
        lp_s <= '0;
      end else if (os_tick) begin
        att_s <= att_prod[27:`SDAC_ATT_SHIFT];
        lp_s <= lp_s + 18'(lp_diff >>> deemph_shift(deemph_rate));
      end
    end

    assign fb = 24'(q) <<< `SDAC_Q_SHIFT;

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        integ1 <= '0;
        integ2 <= '0;
        integ3 <= '0;
      end else if (os_tick) begin
        integ1 <= sat24(26'(shaped_s) + 26'(integ1) - 26'(fb));
        integ2 <= sat24(26'(integ2) + 26'(integ1 >>> 1) - 26'(fb));
        integ3 <= sat24(26'(integ3) + 26'(integ2 >>> 2) - 26'(fb));
      end
    end

    assign q = quantise(integ3);

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        level <= `SDAC_PWM_MID;
      end else if (os_tick) begin
        if (mute_on || !zero_n[ch] || att_code == 11'h000) begin
          level <= `SDAC_PWM_MID;
        end else begin
          level <= 5'(q + `SDAC_PWM_MID);
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        pwm_a[ch] <= 1'b0;
        pwm_b[ch] <= 1'b0;
      end else begin
        pwm_a[ch] <= ({1'b0, frame_cnt[3:0]} < level);
        pwm_b[ch] <= ({1'b0, frame_cnt[3:0]} < (`SDAC_PWM_TOP - level));
      end
    end

    always_comb begin
      next_zero_cnt = zero_cnt;
      if (taken) begin
        if (new_s != '0) begin
          next_zero_cnt = 14'h0000;
        end else if (zero_cnt < zd_period) begin
          next_zero_cnt = zero_cnt + 14'h0001;
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        zero_cnt <= 14'h0000;
        zero_n[ch] <= 1'b1;
      end else begin
        zero_cnt <= next_zero_cnt;
        zero_n[ch] <= (next_zero_cnt < zd_period);
      end
    end
  end

  assign left_pwm_a = pwm_a[0];
  assign left_pwm_b = pwm_b[0];
  assign right_pwm_a = pwm_a[1];
  assign right_pwm_b = pwm_b[1];
  assign left_zero_flag_n = zero_n[0];
  assign right_zero_flag_n = zero_n[1];

endmodule
`default_nettype wire

// ===== verif/sdac_host_model.sv
// Host controller model writing control words over the serial port.
// Assumes the caller sets the moment; shift clock runs only inside words.
`timescale 1ns/1ps
`default_nettype none
module sdac_host_model (
  output logic shift_clock,
  output logic control_serial_in,
  output logic control_latch
);
  initial begin
    shift_clock = 1'b1;
    control_serial_in = 1'b0;
    control_latch = 1'b1;
  end
  // Bad lets a scenario send a word the host must never send
  task automatic write_word(input logic [15:0] w, input logic bad);
    logic [15:0] v;
    v = w;
    if (!bad) begin
      v[15] = 1'b0;
      if (v[14]) v = v & 16'h502e;
      else begin
        v[11] = 1'b0;
        if (v[10:0] > 11'h400) v[10:0] = 11'h400;
      end
    end
    #13;
    // LSB first, 80 ns shift period
    for (int i = 0; i < 16; i++) begin
      shift_clock = 1'b0;
      control_serial_in = v[i];
      #40 shift_clock = 1'b1;
      #40;
    end
    // Released line shows the inverse; clock stays high over the latch
    control_serial_in = ~v[15];
    control_latch = 1'b0;
    #400 control_latch = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// ===== verif/sdac_top_asserts.sv
// Pin-level checks on the stereo DAC outputs.
// Assumes only the sys_clk domain is watched; bound into every sdac_top.
`timescale 1ns/1ps
`default_nettype none
module sdac_top_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic left_pwm_a,
  input wire logic left_pwm_b,
  input wire logic right_pwm_a,
  input wire logic right_pwm_b,
  input wire logic left_zero_flag_n,
  input wire logic right_zero_flag_n
);
  default clocking cb @(posedge sys_clk); endclocking
  logic [4:0] lhi, llo, rhi, rlo;
  logic [5:0] lmu, rmu;
  ////////////////////////////////////////////////////////////////
  // Run lengths of pair activity; a slot is 16 clocks, 2 at least idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lhi <= 5'h00;
      llo <= 5'h00;
      rhi <= 5'h00;
      rlo <= 5'h00;
    end else begin
      lhi <= (left_pwm_a | left_pwm_b) ? lhi + 5'h01 : 5'h00;
      llo <= (left_pwm_a | left_pwm_b) ? 5'h00 : llo + 5'h01;
      rhi <= (right_pwm_a | right_pwm_b) ? rhi + 5'h01 : 5'h00;
      rlo <= (right_pwm_a | right_pwm_b) ? 5'h00 : rlo + 5'h01;
    end
  end
  // Saturating, so a long silence cannot wrap back under the limit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lmu <= 6'h00;
      rmu <= 6'h00;
    end else begin
      lmu <= left_zero_flag_n ? 6'h00 : lmu + {5'h00, lmu != 6'h3f};
      rmu <= right_zero_flag_n ? 6'h00 : rmu + {5'h00, rmu != 6'h3f};
    end
  end
  ////////////////////////////////////////////////////////////////
  a_rst_pwm_low: assert property (rst |=>
    !(left_pwm_a | left_pwm_b | right_pwm_a | right_pwm_b)) else $error("pwm not low in reset");
  a_rst_flags_high: assert property (rst |=>
    left_zero_flag_n && right_zero_flag_n) else $error("zero flag low in reset");
  a_left_hi_max: assert property (disable iff (rst) lhi <= 5'h0e)
    else $error("left pair active too long");
  a_left_lo_max: assert property (disable iff (rst) llo <= 5'h09)
    else $error("left pair idle too long");
  a_right_hi_max: assert property (disable iff (rst) rhi <= 5'h0e)
    else $error("right pair active too long");
  a_right_lo_max: assert property (disable iff (rst) rlo <= 5'h09)
    else $error("right pair idle too long");
  a_left_mute_mid: assert property (disable iff (rst) lmu > 6'h28 |->
    left_pwm_a == left_pwm_b) else $error("left not at zero data");
  a_right_mute_mid: assert property (disable iff (rst) rmu > 6'h28 |->
    right_pwm_a == right_pwm_b) else $error("right not at zero data");
  c_left_zero: cover property (disable iff (rst) lmu == 6'h3f);
  c_right_zero: cover property (disable iff (rst) rmu == 6'h3f);
  c_release: cover property (rst ##1 !rst);
endmodule
bind sdac_top sdac_top_asserts sdac_top_asserts_i (.sys_clk, .rst, .left_pwm_a, .left_pwm_b,
  .right_pwm_a, .right_pwm_b, .left_zero_flag_n, .right_zero_flag_n);
`default_nettype wire

// ===== verif/sdac_top_test.sv
// Self-checking bench for the stereo DAC control and output path.
// Assumes the host model drives the control pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module sdac_top_test;
  import sdac_pkg::*;
  typedef struct {
    logic [15:0] cfg;
    logic [17:0] l;
    logic [17:0] r;
    int n;
    logic [1:0] ef;
  } sdac_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic abck = 1'b0, wsel = 1'b0, adat = 1'b0;
  wire logic shift_clock, control_serial_in, control_latch;
  logic la, lb, ra, rb, lz, rz;
  int err_total = 0;
  int tests_run = 0;
  // Short zero-detect periods: 3 and 6 samples
  sdac_row_t rows [8] = '{
    '{16'h0000, 18'h00000, 18'h00000, 2, 2'b11},
    '{16'h0000, 18'h00000, 18'h00000, 1, 2'b00},
    '{16'h0000, 18'h00100, 18'h00000, 1, 2'b10},
    '{16'h0020, 18'h00000, 18'h00000, 5, 2'b10},
    '{16'h0020, 18'h00000, 18'h00000, 1, 2'b00},
    '{16'h0020, 18'h00000, 18'h3ff00, 1, 2'b01},
    '{16'h0000, 18'h20000, 18'h00000, 3, 2'b00},
    '{16'h1000, 18'h20000, 18'h00000, 1, 2'b10}};
  logic [16:0] hw [6] = '{17'h04000, 17'h01400, 17'h00000, 17'h18400, 17'h00400, 17'h02400};
  logic [5:0] ex = 6'b110001;
  always #25 sys_clk = ~sys_clk;
  sdac_host_model sdac_host_model_i (.shift_clock(shift_clock),
    .control_serial_in(control_serial_in), .control_latch(control_latch));
  sdac_top #(.ZD_SHORT(3), .ZD_LONG(6)) sdac_top_i (.sys_clk(sys_clk), .rst(rst),
    .shift_clock(shift_clock), .control_serial_in(control_serial_in),
    .control_latch(control_latch), .audio_bit_clock(abck), .word_select_clock(wsel),
    .audio_data_in(adat), .left_pwm_a(la), .left_pwm_b(lb), .right_pwm_a(ra),
    .right_pwm_b(rb), .left_zero_flag_n(lz), .right_zero_flag_n(rz));
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One stereo pair: 64 bits per half, sample in the last 18, MSB first
  task automatic send_pair(input logic [17:0] l, input logic [17:0] r);
    for (int i = 0; i < 128; i++) begin
      cyc(2);
      wsel = i[6];
      abck = 1'b0;
      adat = (i[5:0] < 46) ? 1'b0 : (i[6] ? r[63 - i[5:0]] : l[63 - i[5:0]]);
      cyc(2);
      abck = 1'b1;
    end
    cyc(2);
    wsel = 1'b0;
  endtask
  // Counts clocks where a pair is not at zero data
  task automatic diff(output logic [7:0] n);
    n = 8'h00;
    cyc(64);
    repeat (64) begin
      cyc(1);
      if (la !== lb || ra !== rb) n = n + 8'h01;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] n;
    cyc(4);
    check("reset pins", 6'h03, {la, lb, ra, rb, lz, rz});
    $display("reset test done");
    rst = 1'b0;
    cyc(2);
    for (int k = 0; k < 8; k++) begin
      sdac_host_model_i.write_word(rows[k].cfg | 16'h4000, 1'b0);
      repeat (rows[k].n) send_pair(rows[k].l, rows[k].r);
      cyc(1100);
      check("zero flags", rows[k].ef, {lz, rz});
      $display("flag row %0d done", k);
    end
    fork
      forever send_pair(18'h14000, 18'h14000);
    join_none
    for (int k = 0; k < 6; k++) begin
      sdac_host_model_i.write_word(hw[k][15:0], hw[k][16]);
      diff(n);
      check("pwm active", ex[k], n != 8'h00);
      $display("level step %0d done", k);
    end
    for (int r = 0; r < 4; r++) begin
      sdac_host_model_i.write_word(16'h4002 | 16'(r << 2), 1'b0);
      diff(n);
      check("deemph active", 1'b1, n != 8'h00);
      $display("rate %0d done", r);
    end
    // Mute by code zero, then a reset in mid run must bring back unity
    sdac_host_model_i.write_word(16'h0000, 1'b0);
    diff(n);
    check("code zero", 1'b0, n != 8'h00);
    rst = 1'b1;
    cyc(4);
    check("reset again", 6'h03, {la, lb, ra, rb, lz, rz});
    rst = 1'b0;
    cyc(1600);
    diff(n);
    check("level after reset", 1'b1, n != 8'h00);
    $display("mid reset done");
    finish_test();
  end
endmodule
`default_nettype wire
